// [serc_core.sv]
// module: secondary bus error response, poison and retry expiry
// assumes: pin-level inputs arrive asynchronously, request/retry
// strobes come from same-clock bridge logic
//
// Function
// - parity response set: detect and report errors
// - response clear (reset): ignore errors, carry on
// - always generate outgoing parity
// - data errors always forward poisoned data
// - interrupt pin field reads zero
// - interrupt line read-only, reads all ones
// - limit zero resets, never expires
// - one-hot limit selects 256/64K/16M/2G
// - count retries, drop request at threshold
// - upper retry register bits read zero
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module serc_core
    import serc_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic pin_addr_err,
    input wire logic pin_data_err,
    input wire logic [DATA_W-1:0] up_data,
    input wire logic up_valid,
    output logic [DATA_W-1:0] fwd_data,
    output logic fwd_valid,
    output logic fwd_poison,
    input wire logic [DATA_W-1:0] out_data,
    output logic out_par,
    output logic err_report,
    input wire logic req_start,
    input wire logic req_retry,
    input wire logic req_done,
    output logic req_drop,
    output logic irq
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] s1_r, s2_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
        end else begin
            s1_r <= {pin_data_err, pin_addr_err};
            s2_r <= s1_r;
        end
    end
    logic addr_err, data_err;
    assign addr_err = s2_r[0];
    assign data_err = s2_r[1];

    // ------------------------------------------------------------
    // registers and error path
    // ------------------------------------------------------------
    logic peresp_r, peresp_nxt;
    logic [3:0] limit_r, limit_nxt;
    logic [SERC_NEV-1:0] stat_r, stat_nxt, en_r, en_nxt, ev;
    logic [31:0] rdata_r, rdata_nxt;
    logic [15:0] errcnt_r, errcnt_nxt;
    logic [DATA_W-1:0] fwd_data_r, fwd_data_nxt;
    logic fwd_valid_r, fwd_valid_nxt, fwd_poison_r, fwd_poison_nxt;
    logic par_r, par_nxt, rep_r, rep_nxt, irq_r, irq_nxt;
    logic drop_r, drop_nxt;
    logic expire;

    always_comb begin
        peresp_nxt = peresp_r;
        limit_nxt = limit_r;
        en_nxt = en_r;
        if (reg_wr && reg_addr == SERC_BRIDGE_CTL_OFS) begin
            peresp_nxt = reg_wdata[SERC_PERESP_BIT];
        end
        if (reg_wr && reg_addr == SERC_RETRY_LIMIT_OFS) begin
            limit_nxt = reg_wdata[3:0];
        end
        if (reg_wr && reg_addr == SERC_IRQ_ENABLE_OFS) begin
            en_nxt = reg_wdata[SERC_NEV-1:0];
        end
        ev = '0;
        ev[SERC_EV_ADDR] = peresp_r && addr_err;
        ev[SERC_EV_DATA] = peresp_r && data_err;
        ev[SERC_EV_EXPIRE] = expire;
        stat_nxt = stat_r;
        if (reg_wr && reg_addr == SERC_IRQ_CLEAR_OFS) begin
            stat_nxt = stat_r & ~reg_wdata[SERC_NEV-1:0];
        end
        stat_nxt = stat_nxt | ev;
        errcnt_nxt = errcnt_r;
        if ((ev[SERC_EV_ADDR] || ev[SERC_EV_DATA]) && errcnt_r != 16'hFFFF)
        begin
            errcnt_nxt = errcnt_r + 16'h0001;
        end
        rep_nxt = ev[SERC_EV_ADDR] | ev[SERC_EV_DATA];
        irq_nxt = |(stat_nxt & en_nxt);
        fwd_data_nxt = up_data;
        fwd_valid_nxt = up_valid;
        fwd_poison_nxt = up_valid && data_err;
        par_nxt = ^out_data;
        rdata_nxt = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                SERC_BRIDGE_CTL_OFS: begin
                    rdata_nxt[SERC_PERESP_BIT] = peresp_r;
                    rdata_nxt[15:8] = SERC_IRQ_PIN_VAL;
                    rdata_nxt[7:0] = SERC_IRQ_LINE_VAL;
                end
                SERC_RETRY_LIMIT_OFS: begin
                    rdata_nxt[3:0] = limit_r;
                end
                SERC_IRQ_STATUS_OFS: begin
                    rdata_nxt[SERC_NEV-1:0] = stat_r;
                end
                SERC_IRQ_ENABLE_OFS: begin
                    rdata_nxt[SERC_NEV-1:0] = en_r;
                end
                SERC_ERR_COUNT_OFS: begin
                    rdata_nxt[15:0] = errcnt_r;
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            peresp_r <= SERC_PERESP_RST;
            limit_r <= SERC_LIMIT_RST;
            en_r <= '0;
            stat_r <= '0;
            errcnt_r <= 16'h0000;
            rep_r <= 1'b0;
            irq_r <= 1'b0;
            fwd_data_r <= '0;
            fwd_valid_r <= 1'b0;
            fwd_poison_r <= 1'b0;
            par_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            peresp_r <= peresp_nxt;
            limit_r <= limit_nxt;
            en_r <= en_nxt;
            stat_r <= stat_nxt;
            errcnt_r <= errcnt_nxt;
            rep_r <= rep_nxt;
            irq_r <= irq_nxt;
            fwd_data_r <= fwd_data_nxt;
            fwd_valid_r <= fwd_valid_nxt;
            fwd_poison_r <= fwd_poison_nxt;
            par_r <= par_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // retry expiry counter
    // ------------------------------------------------------------
    serc_state_type st_r, st_nxt;
    logic [31:0] rcnt_r, rcnt_nxt, thresh;

    always_comb begin
        case (limit_r)
            SERC_LIM_256: thresh = SERC_CNT_256;
            SERC_LIM_64K: thresh = SERC_CNT_64K;
            SERC_LIM_16M: thresh = SERC_CNT_16M;
            SERC_LIM_2G: thresh = SERC_CNT_2G;
            default: thresh = 32'h0000_0000;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        rcnt_nxt = rcnt_r;
        expire = 1'b0;
        drop_nxt = 1'b0;
        case (st_r)
            SERC_IDLE: begin
                if (req_start) begin
                    st_nxt = SERC_BUSY;
                    rcnt_nxt = 32'h0000_0000;
                end
            end
            SERC_BUSY: begin
                if (req_done) begin
                    st_nxt = SERC_IDLE;
                end else if (req_retry) begin
                    rcnt_nxt = rcnt_r + 32'h0000_0001;
                    if (thresh != 32'h0000_0000 && rcnt_nxt >= thresh) begin
                        expire = 1'b1;
                        drop_nxt = 1'b1;
                        st_nxt = SERC_IDLE;
                    end
                end
            end
            default: begin
                st_nxt = SERC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= SERC_IDLE;
            rcnt_r <= 32'h0000_0000;
            drop_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            rcnt_r <= rcnt_nxt;
            drop_r <= drop_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign fwd_data = fwd_data_r;
    assign fwd_valid = fwd_valid_r;
    assign fwd_poison = fwd_poison_r;
    assign out_par = par_r;
    assign err_report = rep_r;
    assign req_drop = drop_r;
    assign irq = irq_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence retry_at_limit;
        st_r == SERC_BUSY && !req_done && req_retry &&
            thresh != 32'h0000_0000 && rcnt_r + 32'h0000_0001 >= thresh;
    endsequence

    err_ignored_a: assert property (
        !peresp_r |=> !err_report)
        else $error("error reported while response disabled");
    err_reported_a: assert property (
        peresp_r && addr_err |=> err_report && stat_r[SERC_EV_ADDR])
        else $error("address error not reported");
    parity_gen_a: assert property (
        1'b1 |=> out_par == ^$past(out_data))
        else $error("parity wrong");
    poison_fwd_a: assert property (
        up_valid && data_err |=> fwd_poison && fwd_valid)
        else $error("data error not poisoned");
    irq_pin_a: assert property (
        reg_rd && reg_addr == SERC_BRIDGE_CTL_OFS |=>
            reg_rdata[15:8] == 8'h00)
        else $error("interrupt pin not zero");
    irq_line_a: assert property (
        reg_rd && reg_addr == SERC_BRIDGE_CTL_OFS |=>
            reg_rdata[7:0] == 8'hFF)
        else $error("interrupt line not all ones");
    no_expire_a: assert property (
        limit_r == 4'h0 |=> !req_drop)
        else $error("drop with counting disabled");
    drop_limit_a: assert property (
        retry_at_limit |=> req_drop ##1 !req_drop)
        else $error("drop not a single pulse at limit");
    thresh_sel_a: assert property (
        limit_r == SERC_LIM_256 |-> thresh == 32'h0000_0100)
        else $error("256 threshold wrong");
    reserved_a: assert property (
        reg_rd && reg_addr == SERC_RETRY_LIMIT_OFS |=>
            reg_rdata[31:4] == 28'h000_0000)
        else $error("reserved bits nonzero");
    restart_a: assert property (
        st_r == SERC_IDLE && req_start |=> rcnt_r == 32'h0000_0000)
        else $error("count not restarted");

    sequence data_err_seen;
        peresp_r && data_err;
    endsequence

    sequence data_err_shown;
        err_report && stat_r[SERC_EV_DATA];
    endsequence

    data_reported_a: assert property (
        data_err_seen |=> data_err_shown)
        else $error("data error not reported");
    addr_ignored_a: assert property (
        !peresp_r |=> !$rose(stat_r[SERC_EV_ADDR]) &&
            !$rose(stat_r[SERC_EV_DATA]))
        else $error("error status set while response disabled");
    poison_clear_a: assert property (
        !(up_valid && data_err) |=> !fwd_poison)
        else $error("poison without data error");
    fwd_copy_a: assert property (
        up_valid |=> fwd_valid && fwd_data == $past(up_data))
        else $error("forwarded data lost");
    fwd_idle_a: assert property (
        !up_valid |=> !fwd_valid)
        else $error("forward valid without input");
    resp_read_a: assert property (
        reg_rd && reg_addr == SERC_BRIDGE_CTL_OFS |=>
            reg_rdata[SERC_PERESP_BIT] == $past(peresp_r))
        else $error("response enable readback wrong");
    limit_read_a: assert property (
        reg_rd && reg_addr == SERC_RETRY_LIMIT_OFS |=>
            reg_rdata[3:0] == $past(limit_r))
        else $error("retry limit readback wrong");
    thresh_64k_a: assert property (
        limit_r == SERC_LIM_64K |-> thresh == 32'h0001_0000)
        else $error("64K threshold wrong");
    thresh_16m_a: assert property (
        limit_r == SERC_LIM_16M |-> thresh == 32'h0100_0000)
        else $error("16M threshold wrong");
    thresh_2g_a: assert property (
        limit_r == SERC_LIM_2G |-> thresh == 32'h8000_0000)
        else $error("2G threshold wrong");
    thresh_other_a: assert property (
        !$onehot(limit_r) |-> thresh == 32'h0000_0000)
        else $error("unlisted code enables counting");
    no_drop_other_a: assert property (
        !$onehot(limit_r) |=> !req_drop)
        else $error("drop with unlisted limit code");
    count_step_a: assert property (
        st_r == SERC_BUSY && req_retry && !req_done |=>
            rcnt_r == $past(rcnt_r) + 32'h0000_0001)
        else $error("retry not counted");
    count_hold_a: assert property (
        st_r == SERC_BUSY && !req_retry |=> rcnt_r == $past(rcnt_r))
        else $error("count moved without retry");
    drop_retry_a: assert property (
        req_drop |-> $past(req_retry) && $past(st_r) == SERC_BUSY)
        else $error("drop without retry");
    done_no_drop_a: assert property (
        st_r == SERC_BUSY && req_done |=> !req_drop && st_r == SERC_IDLE)
        else $error("completed request dropped");
    drop_status_a: assert property (
        req_drop |-> stat_r[SERC_EV_EXPIRE])
        else $error("expiry not flagged");
    sticky_set_a: assert property (
        ev != '0 |=> (stat_r & $past(ev)) == $past(ev))
        else $error("event lost against clear");
    irq_level_a: assert property (
        irq == |(stat_r & en_r))
        else $error("interrupt level wrong");
    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
    errcnt_sat_a: assert property (
        errcnt_r == 16'hFFFF |=> errcnt_r == 16'hFFFF)
        else $error("error count wrapped");
endmodule

// [serc_pkg.sv]
// package: secondary error and retry control constants
// assumes: shared by the single design module and its testbench
package serc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] SERC_RETRY_LIMIT_OFS = 12'h0040;
    localparam logic [11:0] SERC_BRIDGE_CTL_OFS = 12'h003C;
    localparam logic [11:0] SERC_IRQ_STATUS_OFS = 12'h0100;
    localparam logic [11:0] SERC_IRQ_ENABLE_OFS = 12'h0104;
    localparam logic [11:0] SERC_IRQ_CLEAR_OFS = 12'h0108;
    localparam logic [11:0] SERC_ERR_COUNT_OFS = 12'h010C;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int SERC_PERESP_BIT = 16;
    localparam logic [7:0] SERC_IRQ_PIN_VAL = 8'h00;
    localparam logic [7:0] SERC_IRQ_LINE_VAL = 8'hFF;
    localparam logic [3:0] SERC_LIMIT_RST = 4'h0;
    localparam logic SERC_PERESP_RST = 1'b0;
    localparam logic [3:0] SERC_LIM_OFF = 4'h0;
    localparam logic [3:0] SERC_LIM_256 = 4'h1;
    localparam logic [3:0] SERC_LIM_64K = 4'h2;
    localparam logic [3:0] SERC_LIM_16M = 4'h4;
    localparam logic [3:0] SERC_LIM_2G = 4'h8;
    localparam logic [31:0] SERC_CNT_256 = 32'h0000_0100;
    localparam logic [31:0] SERC_CNT_64K = 32'h0001_0000;
    localparam logic [31:0] SERC_CNT_16M = 32'h0100_0000;
    localparam logic [31:0] SERC_CNT_2G = 32'h8000_0000;
    // interrupt status bit positions
    localparam int SERC_EV_ADDR = 0;
    localparam int SERC_EV_DATA = 1;
    localparam int SERC_EV_EXPIRE = 2;
    localparam int SERC_NEV = 3;
    // ------------------------------------------------------------
    // retry tracker states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        SERC_IDLE = 1'b0,
        SERC_BUSY = 1'b1
    } serc_state_type;
endpackage

// [serc_agent.sv]
// model: secondary bus target answering requests with retries
// assumes: same clock as serc_core, go pulses only while not busy
`timescale 1ns/10ps
module serc_agent (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [31:0] nretry,
    output logic req_start,
    output logic req_retry,
    output logic req_done,
    output logic busy
);
    // ------------------------------------------------------------
    // one request, nretry retries back to back, then completion
    // ------------------------------------------------------------
    initial begin
        req_start = 1'b0;
        req_retry = 1'b0;
        req_done = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go === 1'b1 && rst_n === 1'b1) begin
                busy <= 1'b1;
                req_start <= 1'b1;
                @(posedge clk);
                req_start <= 1'b0;
                repeat (nretry) begin
                    req_retry <= 1'b1;
                    @(posedge clk);
                end
                req_retry <= 1'b0;
                repeat (2) @(posedge clk);
                req_done <= 1'b1;
                @(posedge clk);
                req_done <= 1'b0;
                busy <= 1'b0;
            end
        end
    end
endmodule

// [secondary_error_retry_control_test.sv]
// testbench: registers, error response, poison, parity, retry expiry
// assumes: serc_pkg compiled first, serc_agent stands at far side
`timescale 1ns/10ps
module secondary_error_retry_control_test;
    import serc_pkg::*;
    logic clk, rst_n, reg_wr, reg_rd, pin_addr_err, pin_data_err;
    logic up_valid, go, fwd_valid, fwd_poison, out_par, err_report;
    logic req_drop, irq, req_start, req_retry, req_done, busy;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, up_data, out_data, fwd_data;
    logic [31:0] rnd, nr, v;
    logic [3:0] lims [6];
    int cnts [6];
    int errors, compares, reps, drops, d0;
    serc_core dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_addr_err(pin_addr_err),
        .pin_data_err(pin_data_err), .up_data(up_data),
        .up_valid(up_valid), .fwd_data(fwd_data), .fwd_valid(fwd_valid),
        .fwd_poison(fwd_poison), .out_data(out_data), .out_par(out_par),
        .err_report(err_report), .req_start(req_start),
        .req_retry(req_retry), .req_done(req_done),
        .req_drop(req_drop), .irq(irq));
    serc_agent agent (.clk(clk), .rst_n(rst_n), .go(go), .nretry(nr),
        .req_start(req_start), .req_retry(req_retry),
        .req_done(req_done), .busy(busy));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction
    function automatic int exp_drop(input logic [3:0] l, input int n);
        return (l == SERC_LIM_256 && n >= 256) ? 1 : 0;
    endfunction
    task chk_reg(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t value %h expected %h", $time, g, e);
        end
    endtask
    task chk_bit(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk_reg(reg_rdata, e);
    endtask
    task run(input int n);
        @(posedge clk);
        go <= 1'b1;
        nr <= n;
        @(posedge clk);
        go <= 1'b0;
        #1;
        for (int i = 0; i < 2000 && busy === 1'b1; i++) @(posedge clk);
        if (busy !== 1'b0) begin
            errors++;
            $display("BAD %0t request never finished", $time);
        end
    endtask
    task close_out;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------
    // clock, monitors, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rst_n === 1'b1 && err_report !== 1'b0) reps++;
        if (rst_n === 1'b1 && req_drop !== 1'b0) drops++;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        close_out();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {rst_n, reg_wr, reg_rd, pin_addr_err, pin_data_err} = 5'h0;
        {up_valid, go, reg_addr, reg_wdata, up_data, out_data} = '0;
        nr = 32'h0000_0000;
        rnd = 32'hd309_f1a6;
        lims = '{SERC_LIM_OFF, SERC_LIM_256, SERC_LIM_256, SERC_LIM_256,
            4'h3, SERC_LIM_64K};
        cnts = '{300, 255, 255, 256, 300, 300};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdc(SERC_BRIDGE_CTL_OFS, 32'h0000_00FF);
        rdc(SERC_RETRY_LIMIT_OFS, 32'h0000_0000);
        wr(SERC_BRIDGE_CTL_OFS, 32'hFFFE_FFFF);
        rdc(SERC_BRIDGE_CTL_OFS, 32'h0000_00FF);
        wr(SERC_RETRY_LIMIT_OFS, 32'hFFFF_FFFF);
        rdc(SERC_RETRY_LIMIT_OFS, 32'h0000_000F);
        rdc(12'h00F0, 32'h0000_0000);
        $display("test registers done");
        pin_addr_err <= 1'b1;
        for (int p = 1; p >= 0; p--) begin
            pin_data_err <= p[0];
            repeat (4) @(posedge clk);
            rnd = lfsr(rnd);
            up_valid <= 1'b1;
            up_data <= rnd;
            v = rnd;
            @(posedge clk);
            up_valid <= 1'b0;
            #1 chk_reg(fwd_data, v);
            chk_bit(fwd_poison, p[0]);
            chk_bit(fwd_valid, 1'b1);
            @(posedge clk);
            #1 chk_bit(fwd_valid, 1'b0);
        end
        pin_addr_err <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            @(posedge clk);
            out_data <= rnd;
            v = rnd;
            @(posedge clk);
            #1 chk_bit(out_par, ^v);
        end
        chk_reg(reps, 0);
        rdc(SERC_IRQ_STATUS_OFS, 32'h0000_0000);
        $display("test errors ignored done");
        cnts[0] = 50 + (lfsr(rnd) & 32'h0000_00C7);
        for (int k = 0; k < 6; k++) begin
            wr(SERC_RETRY_LIMIT_OFS, {28'h000_0000, lims[k]});
            d0 = drops;
            run(cnts[k]);
            d0 = drops - d0;
            chk_reg(d0, exp_drop(lims[k], nr));
        end
        $display("test retry expiry done");
        rdc(SERC_IRQ_STATUS_OFS, 32'h0000_0004);
        chk_bit(irq, 1'b0);
        wr(SERC_IRQ_ENABLE_OFS, 32'h0000_0004);
        repeat (2) @(posedge clk);
        #1 chk_bit(irq, 1'b1);
        wr(SERC_IRQ_CLEAR_OFS, 32'h0000_0007);
        repeat (2) @(posedge clk);
        #1 chk_bit(irq, 1'b0);
        rdc(SERC_IRQ_STATUS_OFS, 32'h0000_0000);
        $display("test interrupt done");
        wr(SERC_BRIDGE_CTL_OFS, 32'h0001_0000);
        rdc(SERC_BRIDGE_CTL_OFS, 32'h0001_00FF);
        @(posedge clk);
        pin_addr_err <= 1'b1;
        pin_data_err <= 1'b1;
        repeat (4) @(posedge clk);
        up_valid <= 1'b1;
        @(posedge clk);
        up_valid <= 1'b0;
        #1 chk_bit(fwd_poison, 1'b1);
        @(posedge clk);
        pin_addr_err <= 1'b0;
        pin_data_err <= 1'b0;
        repeat (6) @(posedge clk);
        chk_reg(reps, 6);
        rdc(SERC_IRQ_STATUS_OFS, 32'h0000_0003);
        rdc(SERC_ERR_COUNT_OFS, 32'h0000_0006);
        $display("test errors reported done");
        out_data <= 32'h0000_0000;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdc(SERC_BRIDGE_CTL_OFS, 32'h0000_00FF);
        rdc(SERC_RETRY_LIMIT_OFS, 32'h0000_0000);
        rdc(SERC_IRQ_STATUS_OFS, 32'h0000_0000);
        $display("test reset done");
        close_out();
    end
endmodule
